// ===== rtl/cmp_pkg.sv
// constants, field positions and encodings for the dual comparator digital back end
// assumes a 32-bit AXI4-Lite register port and 8-bit registers in the low byte lane
package cmp_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_READBACK_CLEAR = 10'h078;
  localparam logic [IDX_W-1:0] IDX_INPUT_SELECT = 10'h079;
  localparam logic [IDX_W-1:0] IDX_ENABLE_RANGE = 10'h07A;
  localparam logic [IDX_W-1:0] IDX_OUTPUT_OPTIONS = 10'h07B;
  localparam logic [IDX_W-1:0] IDX_LOGIC_FUNCTION = 10'h07C;

  // values after reset
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_ENABLE_RANGE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_OPTIONS = 8'h00;
  localparam logic [7:0] RST_LOGIC_FUNCTION = 8'h00;

  // readback/clear fields
  localparam int POS_CH1_LIVE = 5;
  localparam int POS_CH0_LIVE = 4;
  localparam int POS_CH1_HELD = 1;
  localparam int POS_CH0_HELD = 0;

  // enable/range fields
  localparam int POS_CH1_LOW_POWER = 5;
  localparam int POS_CH1_ON = 4;
  localparam int POS_CH0_LOW_POWER = 1;
  localparam int POS_CH0_ON = 0;

  // output option fields
  localparam int POS_CH1_CONNECT = 7;
  localparam int POS_CH1_PIN_SEL = 6;
  localparam int POS_CH1_CLEAR_SEL = 5;
  localparam int POS_CH1_MAIN_SEL = 4;
  localparam int POS_CH0_CONNECT = 3;
  localparam int POS_CH0_PIN_SEL = 2;
  localparam int POS_CH0_CLEAR_SEL = 1;
  localparam int POS_CH0_MAIN_SEL = 0;

  // input select and function code fields (low bit of each)
  localparam int POS_CH1_POS_SEL = 6;
  localparam int POS_CH1_NEG_SEL = 4;
  localparam int POS_CH0_POS_SEL = 2;
  localparam int POS_CH0_NEG_SEL = 0;
  localparam int POS_CH1_FUNC = 4;
  localparam int POS_CH0_FUNC = 0;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input source codes
  typedef enum logic [1:0] {
    POS_ANALOG_BUS = 2'b00, POS_RESERVED = 2'b01, POS_PAD_A = 2'b10, POS_PAD_B = 2'b11
  } pos_src_t;
  typedef enum logic [1:0] {
    NEG_REF_1V3 = 2'b00, NEG_LOW_REF = 2'b01, NEG_HIGH_REF = 2'b10, NEG_RESERVED = 2'b11
  } neg_src_t;

  // two-input function codes, a = own comparator, b = neighbour
  typedef enum logic [3:0] {
    FN_FALSE = 4'h0, FN_A_ANDN_B = 4'h1, FN_NA_AND_B = 4'h2, FN_A = 4'h3,
    FN_A_AND_B = 4'h4, FN_B = 4'h5, FN_XOR = 4'h6, FN_OR = 4'h7,
    FN_NOR = 4'h8, FN_XNOR = 4'h9, FN_NOT_B = 4'hA, FN_A_ORN_B = 4'hB,
    FN_NOT_A = 4'hC, FN_NA_OR_B = 4'hD, FN_NAND = 4'hE, FN_TRUE = 4'hF
  } func_t;

endpackage

// ===== rtl/cmp_chan_if.sv
// signals between the register side of the top and one comparator channel
// assumes one instance per channel, joined by the top's generate loop
`timescale 1ns/1ps
interface cmp_chan_if;
  import cmp_pkg::*;
  logic own_in;
  logic other_in;
  logic [3:0] func_code;
  logic clear_by_edge;
  logic sw_clear;
  logic other_rise;
  logic main_sel;
  logic pin_sel;
  logic table_out;
  logic table_rise;
  logic held;
  logic main_out;
  logic pin_out;
  modport ctrl (
    output own_in, other_in, func_code, clear_by_edge, sw_clear, other_rise, main_sel, pin_sel,
    input table_out, table_rise, held, main_out, pin_out
  );
  modport chan (
    input own_in, other_in, func_code, clear_by_edge, sw_clear, other_rise, main_sel, pin_sel,
    output table_out, table_rise, held, main_out, pin_out
  );
endinterface

// ===== rtl/cmp_input_sync.sv
// three-stage synchroniser for the asynchronous comparator outputs
// assumes inputs may change at any time; a change is taken once stages two and three agree
`timescale 1ns/1ps
module cmp_input_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // raw and filtered levels
  input wire logic [1:0] i_raw,
  output logic [1:0] o_stable
);
  logic [1:0] stage1;
  logic [1:0] stage2;
  logic [1:0] stage3;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= 2'h0;
      stage2 <= 2'h0;
      stage3 <= 2'h0;
    end else begin
      stage1 <= i_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  logic [1:0] next_stable;

  // per bit: update only when the last two stages agree, filtering a one-stage glitch
  for (genvar b = 0; b < 2; b++) begin : g_bit
    assign next_stable[b] = (stage2[b] == stage3[b]) ? stage3[b] : o_stable[b];
  end

  // one process owns the whole output so no bit has a second driver
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stable <= 2'h0;
    end else begin
      o_stable <= next_stable;
    end
  end
endmodule

// ===== rtl/cmp_channel.sv
// one comparator channel: two-input function table, set/clear latch, output selects
// assumes inputs come from flip-flops on the same clock
`timescale 1ns/1ps
module cmp_channel (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // channel signals
  cmp_chan_if.chan ch
);
  import cmp_pkg::*;

  logic table_prev;
  logic clear_req;

  // a = own comparator, b = neighbour
  always_comb begin
    unique case (func_t'(ch.func_code))
      FN_FALSE: ch.table_out = 1'b0;
      FN_A_ANDN_B: ch.table_out = ch.own_in & ~ch.other_in; // [R16]
      FN_NA_AND_B: ch.table_out = ~ch.own_in & ch.other_in; // [R16]
      FN_A: ch.table_out = ch.own_in; // [R13]
      FN_A_AND_B: ch.table_out = ch.own_in & ch.other_in; // [R16]
      FN_B: ch.table_out = ch.other_in; // [R13]
      FN_XOR: ch.table_out = ch.own_in ^ ch.other_in; // [R13]
      FN_OR: ch.table_out = ch.own_in | ch.other_in; // [R13]
      FN_NOR: ch.table_out = ~(ch.own_in | ch.other_in); // [R13]
      FN_XNOR: ch.table_out = ~(ch.own_in ^ ch.other_in); // [R13]
      FN_NOT_B: ch.table_out = ~ch.other_in; // [R16]
      FN_A_ORN_B: ch.table_out = ch.own_in | ~ch.other_in; // [R16]
      FN_NOT_A: ch.table_out = ~ch.own_in; // [R16]
      FN_NA_OR_B: ch.table_out = ~ch.own_in | ch.other_in; // [R16]
      FN_NAND: ch.table_out = ~(ch.own_in & ch.other_in); // [R13]
      FN_TRUE: ch.table_out = 1'b1; // [R13]
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      table_prev <= 1'b0;
    end else begin
      table_prev <= ch.table_out;
    end
  end
  assign ch.table_rise = ch.table_out & ~table_prev;

  // select 0 clears by register write, 1 by the neighbour's rising edge
  assign clear_req = ch.clear_by_edge ? ch.other_rise : ch.sw_clear; // [R17] [R3] [R4]

  // set beats clear so a high table output in the clear cycle is not lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ch.held <= 1'b0;
    end else if (ch.table_out) begin
      ch.held <= 1'b1; // [R2]
    end else if (clear_req) begin
      ch.held <= 1'b0; // [R15]
    end
  end

  assign ch.main_out = ch.main_sel ? ch.held : ch.table_out; // [R5]
  assign ch.pin_out = ch.pin_sel ? ch.held : ch.table_out; // [R6]
endmodule

// ===== rtl/dual_comparator_logic_latch.sv
// dual comparator digital back end with an AXI4-Lite register port
// assumes the analog comparators drive i_cmp_raw asynchronously and take
// their enables, ranges and input selects from the outputs below
//
// Contract
// [R1] readback bits 5 and 4 show the live, unheld states of channel 1 and channel 0.
// [R2] each channel's held bit (1 for channel 1, 0 for channel 0) sets when its table output is high and stays set until cleared.
// [R3] output-options bit 5 picks how the channel 1 held bit is cleared: register write or channel 0 table rising edge.
// [R4] output-options bit 1 picks how the channel 0 held bit is cleared: register write or channel 1 table rising edge.
// [R5] bits 4 and 0 pick table output or held output as each channel's main result.
// [R6] bits 6 and 2 pick table output or held output as each channel's pin source.
// [R7] bits 7 and 3 connect each comparator's output to the analog output.
// [R8] enable-range bits 4 and 0 switch comparators 1 and 0 on; an off comparator does nothing (here it reads as zero to both tables).
// [R9] enable-range bits 5 and 1 select the low-power, limited-range mode when set.
// [R10] positive select codes mean 00 analog bus, 01 reserved, 10 pad A, 11 pad B.
// [R11] negative select codes mean 00 1.3V reference, 01 low reference, 10 high reference, 11 reserved.
// [R12] the function register holds channel 1's code in bits 7:4 and channel 0's in bits 3:0.
// [R13] codes 0,3,5,6,7,8,9,E,F give false, A, B, xor, or, nor, xnor, nand, true.
// [R14] each table takes its own comparator and the neighbour as inputs.
// [R15] writing zero to a held bit clears it while that channel clears by write.
// [R16] A is the own comparator, B the neighbour; codes 1,2,4,A,B,C,D give A&~B, ~A&B, A&B, ~B, A|~B, ~A, ~A|B.
// [R17] clear select zero clears by write, one by the other channel's rising edge.
`timescale 1ns/1ps
module dual_comparator_logic_latch (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // axi4-lite write address
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [cmp_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic [2:0] i_s_axi_awprot,
  // axi4-lite write data
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [cmp_pkg::DATA_W-1:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // axi4-lite read address
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [cmp_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic [2:0] i_s_axi_arprot,
  // axi4-lite read data
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [cmp_pkg::DATA_W-1:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // raw comparator outputs, bit 1 = comparator 1
  input wire logic [1:0] i_cmp_raw,
  // analog controls, bit 1 = comparator 1
  output logic [1:0] o_cmp_on,
  output logic [1:0] o_cmp_low_power_range,
  output logic [1:0] o_cmp_analog_out_connect,
  // one-hot positive sources: [0] analog bus, [1] pad a, [2] pad b
  output logic [2:0] o_ch1_pos_src,
  output logic [2:0] o_ch0_pos_src,
  // one-hot negative sources: [0] 1.3v ref, [1] low ref, [2] high ref
  output logic [2:0] o_ch1_neg_src,
  output logic [2:0] o_ch0_neg_src,
  // digital results, bit 1 = channel 1
  output logic [1:0] o_main_result,
  output logic [1:0] o_pin_result
);
  import cmp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_n;
  logic rst_n;

  // assert at once, release two edges later so every flop leaves reset together
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] comparator_input_select;
  logic [7:0] comparator_enable_range;
  logic [7:0] comparator_output_options;
  logic [7:0] comparator_logic_function;
  logic [7:0] comparator_readback_clear;

  logic [1:0] ch1_pos_input_sel;
  logic [1:0] ch1_neg_input_sel;
  logic [1:0] ch0_pos_input_sel;
  logic [1:0] ch0_neg_input_sel;
  logic [3:0] ch1_func_code;
  logic [3:0] ch0_func_code;
  logic ch1_on;
  logic ch0_on;
  logic ch1_low_power_range;
  logic ch0_low_power_range;
  logic ch1_analog_out_connect;
  logic ch0_analog_out_connect;
  logic ch1_pin_source_sel;
  logic ch0_pin_source_sel;
  logic ch1_clear_source_sel;
  logic ch0_clear_source_sel;
  logic ch1_main_source_sel;
  logic ch0_main_source_sel;

  assign ch1_pos_input_sel = comparator_input_select[POS_CH1_POS_SEL +: 2];
  assign ch1_neg_input_sel = comparator_input_select[POS_CH1_NEG_SEL +: 2];
  assign ch0_pos_input_sel = comparator_input_select[POS_CH0_POS_SEL +: 2];
  assign ch0_neg_input_sel = comparator_input_select[POS_CH0_NEG_SEL +: 2];
  assign ch1_func_code = comparator_logic_function[POS_CH1_FUNC +: 4]; // [R12]
  assign ch0_func_code = comparator_logic_function[POS_CH0_FUNC +: 4]; // [R12]
  assign ch1_on = comparator_enable_range[POS_CH1_ON];
  assign ch0_on = comparator_enable_range[POS_CH0_ON];
  assign ch1_low_power_range = comparator_enable_range[POS_CH1_LOW_POWER];
  assign ch0_low_power_range = comparator_enable_range[POS_CH0_LOW_POWER];
  assign ch1_analog_out_connect = comparator_output_options[POS_CH1_CONNECT];
  assign ch0_analog_out_connect = comparator_output_options[POS_CH0_CONNECT];
  assign ch1_pin_source_sel = comparator_output_options[POS_CH1_PIN_SEL];
  assign ch0_pin_source_sel = comparator_output_options[POS_CH0_PIN_SEL];
  assign ch1_clear_source_sel = comparator_output_options[POS_CH1_CLEAR_SEL];
  assign ch0_clear_source_sel = comparator_output_options[POS_CH0_CLEAR_SEL];
  assign ch1_main_source_sel = comparator_output_options[POS_CH1_MAIN_SEL];
  assign ch0_main_source_sel = comparator_output_options[POS_CH0_MAIN_SEL];

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write side

  logic aw_held;
  logic w_held;
  logic [IDX_W-1:0] aw_index;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic write_mapped;
  logic [1:0] held_clear_req;

  // address and data are taken independently; no new beat while a response waits
  assign o_s_axi_awready = !aw_held && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_held && !o_s_axi_bvalid;
  assign do_write = aw_held && w_held && !o_s_axi_bvalid;

  always_comb begin
    unique case (aw_index)
      IDX_READBACK_CLEAR, IDX_INPUT_SELECT, IDX_ENABLE_RANGE,
      IDX_OUTPUT_OPTIONS, IDX_LOGIC_FUNCTION: write_mapped = 1'b1;
      default: write_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_index <= '0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= i_s_axi_awaddr[ADDR_W-1:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= i_s_axi_wdata[7:0];
      w_lane0 <= i_s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp <= write_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_input_select <= RST_INPUT_SELECT;
      comparator_enable_range <= RST_ENABLE_RANGE;
      comparator_output_options <= RST_OUTPUT_OPTIONS;
      comparator_logic_function <= RST_LOGIC_FUNCTION;
    end else if (do_write && w_lane0) begin
      unique case (aw_index)
        IDX_INPUT_SELECT: comparator_input_select <= w_byte;
        IDX_ENABLE_RANGE: comparator_enable_range <= w_byte;
        IDX_OUTPUT_OPTIONS: comparator_output_options <= w_byte;
        IDX_LOGIC_FUNCTION: comparator_logic_function <= w_byte;
        default: ;
      endcase
    end
  end

  // a zero written to a held bit asks for a clear; a one leaves it alone
  always_comb begin
    held_clear_req = 2'b00;
    if (do_write && w_lane0 && aw_index == IDX_READBACK_CLEAR) begin
      held_clear_req[1] = ~w_byte[POS_CH1_HELD]; // [R15]
      held_clear_req[0] = ~w_byte[POS_CH0_HELD]; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // comparator inputs and channels

  logic [1:0] cmp_stable;
  logic [1:0] cmp_live;
  logic [1:0] clear_sel;
  logic [1:0] main_sel;
  logic [1:0] pin_sel;
  logic [3:0] func_code [2];
  logic [1:0] table_out;
  logic [1:0] table_rise;
  logic [1:0] held;
  logic [1:0] main_out;
  logic [1:0] pin_out;

  cmp_input_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_raw(i_cmp_raw),
    .o_stable(cmp_stable)
  );

  // a switched-off comparator is held at zero as the own and neighbour input of both tables
  assign cmp_live = cmp_stable & {ch1_on, ch0_on}; // [R8]
  assign clear_sel = {ch1_clear_source_sel, ch0_clear_source_sel};
  assign main_sel = {ch1_main_source_sel, ch0_main_source_sel};
  assign pin_sel = {ch1_pin_source_sel, ch0_pin_source_sel};
  assign func_code[1] = ch1_func_code;
  assign func_code[0] = ch0_func_code;

  cmp_chan_if chan_link[2] ();

  for (genvar c = 0; c < 2; c++) begin : g_chan
    assign chan_link[c].own_in = cmp_live[c]; // [R14]
    assign chan_link[c].other_in = cmp_live[1-c]; // [R14]
    assign chan_link[c].func_code = func_code[c];
    assign chan_link[c].clear_by_edge = clear_sel[c]; // [R3] [R4]
    assign chan_link[c].sw_clear = held_clear_req[c];
    assign chan_link[c].other_rise = table_rise[1-c]; // [R3] [R4]
    assign chan_link[c].main_sel = main_sel[c];
    assign chan_link[c].pin_sel = pin_sel[c];
    assign table_out[c] = chan_link[c].table_out;
    assign table_rise[c] = chan_link[c].table_rise;
    assign held[c] = chan_link[c].held;
    assign main_out[c] = chan_link[c].main_out;
    assign pin_out[c] = chan_link[c].pin_out;

    cmp_channel u_channel (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .ch(chan_link[c].chan)
    );
  end

  // readback view: live table outputs and held states
  always_comb begin
    comparator_readback_clear = 8'h00;
    comparator_readback_clear[POS_CH1_LIVE] = table_out[1]; // [R1]
    comparator_readback_clear[POS_CH0_LIVE] = table_out[0]; // [R1]
    comparator_readback_clear[POS_CH1_HELD] = held[1]; // [R2]
    comparator_readback_clear[POS_CH0_HELD] = held[0]; // [R2]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read side

  logic [IDX_W-1:0] ar_index;
  logic [7:0] read_byte;
  logic read_mapped;

  assign o_s_axi_arready = !o_s_axi_rvalid;
  assign ar_index = i_s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    read_mapped = 1'b1;
    unique case (ar_index)
      IDX_READBACK_CLEAR: read_byte = comparator_readback_clear;
      IDX_INPUT_SELECT: read_byte = comparator_input_select;
      IDX_ENABLE_RANGE: read_byte = comparator_enable_range;
      IDX_OUTPUT_OPTIONS: read_byte = comparator_output_options;
      IDX_LOGIC_FUNCTION: read_byte = comparator_logic_function;
      default: begin
        read_byte = 8'h00;
        read_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= {24'h000000, read_byte};
      o_s_axi_rresp <= read_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // analog controls and results

  // reserved source codes select nothing, leaving the input open
  function automatic logic [2:0] pos_decode(input logic [1:0] code);
    unique case (pos_src_t'(code))
      POS_ANALOG_BUS: pos_decode = 3'h1; // [R10]
      POS_RESERVED: pos_decode = 3'h0; // [R10]
      POS_PAD_A: pos_decode = 3'h2; // [R10]
      POS_PAD_B: pos_decode = 3'h4; // [R10]
    endcase
  endfunction

  function automatic logic [2:0] neg_decode(input logic [1:0] code);
    unique case (neg_src_t'(code))
      NEG_REF_1V3: neg_decode = 3'h1; // [R11]
      NEG_LOW_REF: neg_decode = 3'h2; // [R11]
      NEG_HIGH_REF: neg_decode = 3'h4; // [R11]
      NEG_RESERVED: neg_decode = 3'h0; // [R11]
    endcase
  endfunction

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmp_on <= 2'h0;
      o_cmp_low_power_range <= 2'h0;
      o_cmp_analog_out_connect <= 2'h0;
      o_ch1_pos_src <= 3'h0;
      o_ch0_pos_src <= 3'h0;
      o_ch1_neg_src <= 3'h0;
      o_ch0_neg_src <= 3'h0;
    end else begin
      o_cmp_on <= {ch1_on, ch0_on}; // [R8]
      o_cmp_low_power_range <= {ch1_low_power_range, ch0_low_power_range}; // [R9]
      o_cmp_analog_out_connect <= {ch1_analog_out_connect, ch0_analog_out_connect}; // [R7]
      o_ch1_pos_src <= pos_decode(ch1_pos_input_sel);
      o_ch0_pos_src <= pos_decode(ch0_pos_input_sel);
      o_ch1_neg_src <= neg_decode(ch1_neg_input_sel);
      o_ch0_neg_src <= neg_decode(ch0_neg_input_sel);
    end
  end

  // results are registered, one cycle behind the table and latch
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_main_result <= 2'h0;
      o_pin_result <= 2'h0;
    end else begin
      o_main_result <= main_out; // [R5]
      o_pin_result <= pin_out; // [R6]
    end
  end

endmodule

// ===== test/cmp_props.sv
// assertion checker for the comparator back end, bound to its top module
// assumes one clock and the top's active-low reset
`timescale 1ns/1ps
module cmp_props (
  // clock, reset and handshakes
  input wire logic i_clk, i_resetn, i_s_axi_arvalid, i_s_axi_bready, i_s_axi_rready,
  input wire logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid,
  input wire logic o_s_axi_arready, o_s_axi_rvalid,
  // payloads and controls
  input wire logic [1:0] o_s_axi_bresp, o_cmp_on,
  input wire logic [cmp_pkg::DATA_W-1:0] o_s_axi_rdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////
  wr_hold_a: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response not held");
  rd_hold_a: assert property (
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data not held");
  rd_answer_a: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read not answered");
  rd_busy_a: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready ##1 (o_s_axi_rvalid != $past(i_s_axi_rready)))
    else $error("read busy or release wrong");
  wr_busy_a: assert property (
    o_s_axi_bvalid |-> !(o_s_axi_awready || o_s_axi_wready)
      ##1 (o_s_axi_bvalid != $past(i_s_axi_bready)))
    else $error("write busy or release wrong");
  wr_cause_a: assert property (
    $rose(o_s_axi_bvalid) |-> !$past(o_s_axi_awready) && !$past(o_s_axi_wready))
    else $error("response without both beats");
  rd_upper_a: assert property (
    o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  on_write_a: assert property (
    $changed(o_cmp_on) |-> !$past(o_s_axi_awready) && !$past(o_s_axi_wready))
    else $error("enable moved without a write");
endmodule
bind dual_comparator_logic_latch cmp_props props (.*);

// ===== test/testbench.sv
// self-checking bench for the dual comparator back end
// assumes axi4-lite answers with no fixed delay; raw inputs settle within 8 cycles
`timescale 1ns/1ps
module testbench;
  import cmp_pkg::*;
  localparam logic [11:0] RB = {IDX_READBACK_CLEAR, 2'b00}, ER = {IDX_ENABLE_RANGE, 2'b00};
  localparam logic [11:0] PS = 12'h881, NS = 12'h111;
  localparam logic [33:0] OK = {RESP_OKAY, 32'h0};
  // function truth table indexed by {code, own, neighbour}
  localparam logic [63:0] TT = 64'hF7B3D591E6A8C240;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0;
  logic i_s_axi_bready = 1'b0, i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic [ADDR_W-1:0] i_s_axi_awaddr = 12'h0, i_s_axi_araddr = 12'h0;
  logic [DATA_W-1:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic [2:0] i_s_axi_awprot = 3'h0, i_s_axi_arprot = 3'h0;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic [1:0] i_cmp_raw = 2'h0, o_s_axi_bresp, o_s_axi_rresp, o_cmp_on, o_cmp_low_power_range;
  logic [1:0] o_cmp_analog_out_connect, o_main_result, o_pin_result;
  logic [2:0] o_ch1_pos_src, o_ch0_pos_src, o_ch1_neg_src, o_ch0_neg_src;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [33:0] q[$];
  int err_count = 0;
  int n_tests = 0;
  dual_comparator_logic_latch uut (.*);
  always #25 i_clk = ~i_clk;
  ////////////////////
  task automatic chk(string s, logic [33:0] seen, logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one bus transfer; the expected answer is noted before the request goes out
  task automatic xf(bit wr, logic [11:0] a, logic [7:0] d, logic [33:0] e);
    bit ta, tw, tr, dn;
    q.push_back(e);
    if (wr) begin
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= {24'h0, d};
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_bready <= 1'b1;
    end else begin
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_rready <= 1'b1;
    end
    // ready is combinational, so it is read mid-cycle where it has settled
    do begin
      @(negedge i_clk);
      ta = i_s_axi_awvalid && o_s_axi_awready;
      tw = i_s_axi_wvalid && o_s_axi_wready;
      tr = i_s_axi_arvalid && o_s_axi_arready;
      dn = (o_s_axi_bvalid && i_s_axi_bready) || (o_s_axi_rvalid && i_s_axi_rready);
      @(posedge i_clk);
      if (ta) i_s_axi_awvalid <= 1'b0;
      if (tw) i_s_axi_wvalid <= 1'b0;
      if (tr) i_s_axi_arvalid <= 1'b0;
    end while (!dn);
    i_s_axi_bready <= 1'b0;
    i_s_axi_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (o_s_axi_rvalid && i_s_axi_rready) chk("rdata", {o_s_axi_rresp, o_s_axi_rdata}, q.pop_front());
    if (o_s_axi_bvalid && i_s_axi_bready) chk("bresp", {o_s_axi_bresp, 32'h0}, q.pop_front());
  end
  ////////////////////
  initial begin
    logic [31:0] v;
    logic [1:0] e, lv;
    v = $urandom(3799);
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 6; i++) xf(0, RB + 12'(4 * i), 8'h00, {i == 5 ? RESP_SLVERR : RESP_OKAY, 32'h0});
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      v[7:0] = 8'(k * 8'h55);
      xf(1, RB + 12'h4, v[7:0], OK);
      xf(1, ER + 12'(4 * (k % 3)), v[15:8], OK);
      xf(0, ER + 12'(4 * (k % 3)), 8'h00, {RESP_OKAY, 24'h0, v[15:8]});
      chk("src", {o_ch1_pos_src, o_ch0_pos_src, o_ch1_neg_src, o_ch0_neg_src}, {{2{PS[3*k+:3]}}, {2{NS[3*k+:3]}}});
      if (k % 3 == 0) chk("on", {o_cmp_low_power_range, o_cmp_on}, {v[13], v[9], v[12], v[8]});
      if (k == 1) chk("conn", o_cmp_analog_out_connect, {v[15], v[11]});
    end
    xf(1, ER + 12'h4, 8'h00, OK);
    for (int i = 0; i < 64; i++) begin
      v = $urandom;
      e = v[1:0];
      i_cmp_raw <= i[1:0];
      xf(1, ER, {3'h0, e[1], 3'h0, e[0]}, OK);
      xf(1, ER + 12'h8, {v[7:4], i[5:2]}, OK);
      repeat (8) @(posedge i_clk);
      xf(1, RB, 8'h00, OK);
      lv[0] = TT[{i[5:2], i[0] & e[0], i[1] & e[1]}];
      lv[1] = TT[{v[7:4], i[1] & e[1], i[0] & e[0]}];
      xf(0, RB, 8'h00, {RESP_OKAY, 26'h0, lv, 2'h0, lv});
      chk("result", {o_pin_result, o_main_result}, {lv, lv});
    end
    // one channel clears by its neighbour's rising edge, the other by write
    for (int c = 0; c < 2; c++) begin
      xf(1, ER, 8'h11, OK);
      xf(1, ER + 12'h8, 8'h33, OK);
      xf(1, ER + 12'h4, c ? 8'h70 : 8'h07, OK);
      i_cmp_raw <= 2'(1 << c);
      repeat (8) @(posedge i_clk);
      i_cmp_raw <= 2'h0;
      repeat (8) @(posedge i_clk);
      xf(1, RB, 8'h00, OK);
      xf(0, RB, 8'h00, {RESP_OKAY, 32'(1 << c)});
      chk("held", {o_pin_result, o_main_result}, {2{2'(1 << c)}});
      i_cmp_raw <= 2'(2 >> c);
      repeat (8) @(posedge i_clk);
      xf(0, RB, 8'h00, {RESP_OKAY, 32'(8'h11 << (1 - c))});
      chk("edge", {o_pin_result, o_main_result}, {2{2'(2 >> c)}});
    end
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    finish_test();
  end
endmodule
